// ==== verilog/mcrl_consts.svh ====
`ifndef MCRL_CONSTS_SVH
`define MCRL_CONSTS_SVH

// Register byte offsets
`define MCRL_OFS_CFG 6'h00
`define MCRL_OFS_HCTL 6'h04
`define MCRL_OFS_EOC_RX 6'h08
`define MCRL_OFS_EOC_TX 6'h0c
`define MCRL_OFS_M4 6'h10
`define MCRL_OFS_STAT 6'h14
`define MCRL_OFS_IRQ 6'h18
`define MCRL_OFS_FUNC 6'h1c

// Host control bits
`define MCRL_HCTL_CUST_EN 0
`define MCRL_HCTL_DEACT_REQ 2
`define MCRL_HCTL_CRC_CORRUPT 3
`define MCRL_HCTL_LOOP_TRANSP 4
`define MCRL_HCTL_M4_TRINAL 5

// Interrupt flag bits
`define MCRL_IRQ_M4 1
`define MCRL_IRQ_EOC 2

// M4 byte bit positions
`define MCRL_M4_ACT 0
`define MCRL_M4_DEA 1
`define MCRL_M4_TRI_MASK 8'h43

// Eoc addresses and message codes
`define MCRL_ADDR_NT1 3'h0
`define MCRL_ADDR_BCAST 3'h7
`define MCRL_MSG_LOOP_2BD 8'h50
`define MCRL_MSG_LOOP_B1 8'h51
`define MCRL_MSG_LOOP_B2 8'h52
`define MCRL_MSG_REQ_CRC 8'h53
`define MCRL_MSG_NOTIFY_CRC 8'h54
`define MCRL_MSG_RETURN 8'hff
`define MCRL_MSG_HOLD 8'h00
`define MCRL_MSG_UTC 8'haa

// Reset values
`define MCRL_RST_CFG 8'h00
`define MCRL_RST_HCTL 8'h00
`define MCRL_RST_M4 8'h00

`endif

// ==== verilog/mcrl_pkg.sv ====
package mcrl_pkg;

    // One eoc frame word: address, data/message flag, message
    typedef struct packed {
        logic [2:0] addr;
        logic dm;
        logic [7:0] msg;
    } mcrl_eoc_type;

    // Functions invoked by the automatic eoc processor
    typedef struct packed {
        logic transp;
        logic crc;
        logic loop_d;
        logic loop_b2;
        logic loop_b1;
    } mcrl_func_type;

    typedef enum logic [1:0] {
        MCRL_EOC_AUTO0 = 2'b00,
        MCRL_EOC_AUTO1 = 2'b01,
        MCRL_EOC_TRINAL = 2'b10,
        MCRL_EOC_EVERY = 2'b11
    } mcrl_eoc_mode_type;

    typedef enum logic [1:0] {
        MCRL_M4_DUAL_VER = 2'b00,
        MCRL_M4_DUAL = 2'b01,
        MCRL_M4_DELTA = 2'b10,
        MCRL_M4_EVERY = 2'b11
    } mcrl_m4_mode_type;

    typedef enum logic [1:0] {
        MCRL_TX_HOST = 2'b00,
        MCRL_TX_ECHO = 2'b01,
        MCRL_TX_HOLD = 2'b10,
        MCRL_TX_UTC = 2'b11
    } mcrl_tx_src_type;

endpackage

// ==== verilog/mcrl_top.sv ====
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "mcrl_consts.svh"

module mcrl_top
    import mcrl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Deframer status, same clock domain
    input wire logic nt_mode,
    input wire logic linkup,
    input wire logic sf_sync,
    input wire logic sf_detect,
    // Received maintenance data from the deframer
    input wire logic eoc_frame,
    input wire mcrl_eoc_type eoc_rx,
    input wire logic m4_frame,
    input wire logic [7:0] m4_rx,
    // Toward the framer and timeslot port
    output mcrl_eoc_type eoc_tx,
    output mcrl_func_type loop_ctrl,
    output logic crc_invert,
    output logic customer_transparent,
    output logic deact_response,
    // Event flags
    output logic eoc_load_interrupt,
    output logic m4_change_interrupt
);

    // Host registers
    logic [7:0] maintenance_config_register, host_ctrl, m4_byte_register, m4_init;
    mcrl_eoc_type eoc_message_register, eoc_tx_host;
    // Internal state
    mcrl_eoc_mode_type eoc_mode;
    mcrl_m4_mode_type m4_mode;
    mcrl_tx_src_type tx_src;
    mcrl_eoc_type eoc_last, eoc_echo;
    mcrl_func_type func;
    logic [1:0] tri_cnt, m4_hist;
    logic [7:0] m4_prev, m4_prev2;
    logic sf_sync_q, verified_act, verified_dea;
    // Combinational terms
    logic bus_wr, bus_rd, gate, sync_rise, auto_on, trinal_on;
    logic eoc_same, eoc_qualify, eoc_load, tri_restart, host_eoc_wr, host_m4_wr, m4_load;
    logic [31:0] wr_mask;
    logic [7:0] dual_ok, tri_ok, next_m4;

    // Address that NT answers: NT1 or broadcast
    function automatic logic addr_ok(input logic [2:0] a);
        addr_ok = (a == `MCRL_ADDR_NT1) || (a == `MCRL_ADDR_BCAST);
    endfunction
    // Processor recognises a message code
    function automatic logic msg_known(input logic [7:0] m);
        case (m)
            `MCRL_MSG_LOOP_2BD, `MCRL_MSG_LOOP_B1, `MCRL_MSG_LOOP_B2,
            `MCRL_MSG_REQ_CRC, `MCRL_MSG_NOTIFY_CRC, `MCRL_MSG_RETURN,
            `MCRL_MSG_HOLD: msg_known = 1'b1;
            default: msg_known = 1'b0;
        endcase
    endfunction
    // Bus decode and control terms
    always_comb
    begin
        bus_wr = write && !waitrequest;
        bus_rd = read && !waitrequest;
        wr_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                   {8{byteenable[1]}}, {8{byteenable[0]}}};
        gate = linkup && sf_sync;
        sync_rise = sf_sync && !sf_sync_q;
        eoc_mode = mcrl_eoc_mode_type'(maintenance_config_register[7:6]);
        m4_mode = mcrl_m4_mode_type'(maintenance_config_register[5:4]);
        auto_on = !eoc_mode[1] && nt_mode;
        trinal_on = eoc_mode != MCRL_EOC_EVERY;
        host_eoc_wr = bus_wr && address == `MCRL_OFS_EOC_TX;
        host_m4_wr = bus_wr && address == `MCRL_OFS_M4;
        tri_restart = !gate || (!nt_mode && trinal_on && host_eoc_wr);
        eoc_same = tri_cnt != 2'h0 && eoc_rx == eoc_last;
        eoc_qualify = eoc_frame && trinal_on && eoc_same && tri_cnt == 2'h2
                      && !tri_restart;
        eoc_load = sf_detect && (eoc_qualify
                   || (eoc_frame && eoc_mode == MCRL_EOC_EVERY));
    end
    // Waitrequest drops for one cycle per request; a single wait state
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            waitrequest <= 1'b1;
        else if ((read || write) && waitrequest)
            waitrequest <= 1'b0;
        else
            waitrequest <= 1'b1;
    end
    // Read data is captured as waitrequest drops; unmapped reads return zero
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            readdata <= 32'h0;
        else if (read && waitrequest)
        begin
            case (address)
                `MCRL_OFS_CFG: readdata <= {24'h0, maintenance_config_register};
                `MCRL_OFS_HCTL: readdata <= {24'h0, host_ctrl};
                `MCRL_OFS_EOC_RX: readdata <= {20'h0, eoc_message_register};
                `MCRL_OFS_EOC_TX: readdata <= {20'h0, eoc_tx_host};
                `MCRL_OFS_M4: readdata <= {24'h0, m4_byte_register};
                `MCRL_OFS_STAT: readdata <= {26'h0, nt_mode, sf_sync, linkup,
                                             verified_act, verified_dea, sf_detect};
                `MCRL_OFS_IRQ: readdata <= {29'h0, eoc_load_interrupt,
                                            m4_change_interrupt, 1'b0};
                `MCRL_OFS_FUNC: readdata <= {27'h0, func};
                default: readdata <= 32'h0;
            endcase
        end
    end
    // Configuration and host control registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            maintenance_config_register <= `MCRL_RST_CFG;
            host_ctrl <= `MCRL_RST_HCTL;
        end
        else if (bus_wr && address == `MCRL_OFS_CFG)
            maintenance_config_register <= (writedata[7:0] & wr_mask[7:0])
                | (maintenance_config_register & ~wr_mask[7:0]);
        else if (bus_wr && address == `MCRL_OFS_HCTL)
            host_ctrl <= (writedata[7:0] & wr_mask[7:0]) | (host_ctrl & ~wr_mask[7:0]);
    end
    // Host transmit eoc word
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            eoc_tx_host <= 12'h0;
        else if (host_eoc_wr)
            eoc_tx_host <= (writedata[11:0] & wr_mask[11:0]) | (eoc_tx_host & ~wr_mask[11:0]);
    end
    // Trinal-check history; count saturates at three identical
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tri_cnt <= 2'h0;
            eoc_last <= 12'h0;
        end
        else if (tri_restart)
            tri_cnt <= 2'h0;
        else if (eoc_frame)
        begin
            eoc_last <= eoc_rx;
            tri_cnt <= !eoc_same ? 2'h1 : (tri_cnt == 2'h3 ? 2'h3 : tri_cnt + 2'h1);
        end
    end
    // Received eoc register and its event flag; a load beats a clear
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            eoc_message_register <= 12'h0;
        else if (eoc_load)
            eoc_message_register <= eoc_rx;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            eoc_load_interrupt <= 1'b0;
        else if (eoc_load)
            eoc_load_interrupt <= 1'b1;
        else if (bus_wr && address == `MCRL_OFS_IRQ && byteenable[0]
                 && writedata[`MCRL_IRQ_EOC])
            eoc_load_interrupt <= 1'b0;
    end
    // Choice of transmitted eoc word in NT
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_src <= MCRL_TX_HOST;
            eoc_echo <= 12'h0;
        end
        else if (host_eoc_wr)
            tx_src <= MCRL_TX_HOST;
        else if (eoc_frame && nt_mode && trinal_on && gate)
        begin
            eoc_echo <= eoc_rx;
            if (!addr_ok(eoc_rx.addr))
                tx_src <= MCRL_TX_HOLD;
            else if (eoc_qualify && auto_on)
                tx_src <= msg_known(eoc_rx.msg) ? MCRL_TX_ECHO : MCRL_TX_UTC;
            else if (eoc_qualify)
                tx_src <= MCRL_TX_HOST;
            else if (!eoc_same || tri_cnt != 2'h3)
                tx_src <= MCRL_TX_ECHO;
        end
    end
    // Registered transmit word; LT and every mode always send the host word
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            eoc_tx <= 12'h0;
        else if (!nt_mode || !trinal_on)
            eoc_tx <= eoc_tx_host;
        else
        begin
            unique case (tx_src)
                MCRL_TX_HOST: eoc_tx <= eoc_tx_host;
                MCRL_TX_ECHO: eoc_tx <= eoc_echo;
                MCRL_TX_HOLD: eoc_tx <= {`MCRL_ADDR_NT1, 1'b1, `MCRL_MSG_HOLD};
                MCRL_TX_UTC: eoc_tx <= {`MCRL_ADDR_NT1, 1'b1, `MCRL_MSG_UTC};
            endcase
        end
    end
    // Automatic processor actions on each qualified, addressed message
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            func <= 5'h0;
        else if (!auto_on)
            func <= 5'h0;
        else if (eoc_qualify && addr_ok(eoc_rx.addr))
        begin
            case (eoc_rx.msg)
                `MCRL_MSG_LOOP_2BD: func <= {host_ctrl[`MCRL_HCTL_LOOP_TRANSP],
                                            func.crc, 3'h7};
                `MCRL_MSG_LOOP_B1: func <= {1'b1, func.crc, func.loop_d,
                                           func.loop_b2, 1'b1};
                `MCRL_MSG_LOOP_B2: func <= {1'b1, func.crc, func.loop_d,
                                           1'b1, func.loop_b1};
                `MCRL_MSG_REQ_CRC: func.crc <= 1'b1;
                `MCRL_MSG_RETURN: func <= 5'h0;
                default: func <= func;
            endcase
        end
    end
    // Framer-facing controls, registered
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loop_ctrl <= 5'h0;
            crc_invert <= 1'b0;
            customer_transparent <= 1'b0;
            deact_response <= 1'b0;
        end
        else
        begin
            loop_ctrl <= func;
            crc_invert <= func.crc || host_ctrl[`MCRL_HCTL_CRC_CORRUPT];
            customer_transparent <= host_ctrl[`MCRL_HCTL_CUST_EN]
                || (m4_mode == MCRL_M4_DUAL_VER && verified_act);
            deact_response <= host_ctrl[`MCRL_HCTL_DEACT_REQ]
                || (m4_mode == MCRL_M4_DUAL_VER && verified_dea);
        end
    end

    // M4 history; restarts whenever the link is not up and synced
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            m4_hist <= 2'h0;
            m4_prev <= 8'h0;
            m4_prev2 <= 8'h0;
            sf_sync_q <= 1'b0;
        end
        else
        begin
            sf_sync_q <= sf_sync;
            if (!gate)
                m4_hist <= 2'h0;
            else if (m4_frame)
            begin
                m4_hist <= (m4_hist == 2'h2) ? 2'h2 : m4_hist + 2'h1;
                m4_prev <= m4_rx;
                m4_prev2 <= m4_prev;
            end
        end
    end

    // Per-bit qualification of the M4 byte
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_m4bit
            always_comb
            begin
                dual_ok[i] = m4_hist != 2'h0 && m4_rx[i] == m4_prev[i];
                tri_ok[i] = m4_hist == 2'h2 && dual_ok[i] && m4_prev[i] == m4_prev2[i];
                if (host_ctrl[`MCRL_HCTL_M4_TRINAL] && ((`MCRL_M4_TRI_MASK >> i) & 8'h01) != 8'h0)
                    next_m4[i] = tri_ok[i] ? m4_rx[i] : m4_byte_register[i];
                else if (!m4_mode[1])
                    next_m4[i] = dual_ok[i] ? m4_rx[i] : m4_byte_register[i];
                else
                    next_m4[i] = m4_rx[i];
            end
        end
    endgenerate

    assign m4_load = m4_frame && gate
        && (m4_mode == MCRL_M4_EVERY || next_m4 != m4_byte_register);

    // M4 byte register with host preset and reload on sync regain
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            m4_byte_register <= `MCRL_RST_M4;
            m4_init <= `MCRL_RST_M4;
        end
        else if (host_m4_wr && !gate && byteenable[0])
        begin
            m4_byte_register <= writedata[7:0];
            m4_init <= writedata[7:0];
        end
        else if (sync_rise)
            m4_byte_register <= m4_init;
        else if (m4_load)
            m4_byte_register <= next_m4;
    end

    // M4 change flag; a new event beats a clear
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            m4_change_interrupt <= 1'b0;
        else if (m4_load && !sync_rise)
            m4_change_interrupt <= 1'b1;
        else if (bus_wr && address == `MCRL_OFS_IRQ && byteenable[0]
                 && writedata[`MCRL_IRQ_M4])
            m4_change_interrupt <= 1'b0;
    end

    // Verified act and dea, mode 00 only
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            verified_act <= 1'b0;
            verified_dea <= 1'b0;
        end
        else if (sync_rise)
        begin
            verified_act <= 1'b0;
            verified_dea <= 1'b0;
        end
        else if (m4_frame && gate && m4_mode == MCRL_M4_DUAL_VER)
        begin
            if (host_ctrl[`MCRL_HCTL_M4_TRINAL] ? tri_ok[`MCRL_M4_ACT] : dual_ok[`MCRL_M4_ACT])
                verified_act <= m4_rx[`MCRL_M4_ACT];
            if (nt_mode && (host_ctrl[`MCRL_HCTL_M4_TRINAL] ? tri_ok[`MCRL_M4_DEA]
                                                             : dual_ok[`MCRL_M4_DEA]))
                verified_dea <= !m4_rx[`MCRL_M4_DEA];
        end
    end

    // Checks
    sequence bad_addr_frame_s;
        eoc_frame && nt_mode && trinal_on && gate && !host_eoc_wr && !addr_ok(eoc_rx.addr);
    endsequence

    eoc_hold_sub_a: assert property (@(posedge clock) disable iff (!rst_b)
        bad_addr_frame_s |-> ##2 eoc_tx.msg == `MCRL_MSG_HOLD)
        else $error("hold not substituted for bad address");
    eoc_sfd_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        $changed(eoc_message_register) |-> $past(sf_detect))
        else $error("eoc register changed without superframe detect");
    trinal_reset_a: assert property (@(posedge clock) disable iff (!rst_b)
        !gate |=> tri_cnt == 2'h0)
        else $error("trinal check not held in reset");
    trinal_load_a: assert property (@(posedge clock) disable iff (!rst_b)
        eoc_qualify && sf_detect |=> eoc_message_register == $past(eoc_rx)
            && eoc_load_interrupt)
        else $error("third identical eoc not loaded");
    every_load_a: assert property (@(posedge clock) disable iff (!rst_b)
        eoc_frame && sf_detect && eoc_mode == MCRL_EOC_EVERY
            |=> eoc_message_register == $past(eoc_rx))
        else $error("every mode did not load");
    m4_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(m4_change_interrupt) |-> $past(gate))
        else $error("m4 interrupt while link not up");
    vact_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(sf_sync) |=> !verified_act && !verified_dea)
        else $error("verified bits not cleared on sync");
    loop_nt_only_a: assert property (@(posedge clock) disable iff (!rst_b)
        !nt_mode |=> ##1 loop_ctrl == 5'h0)
        else $error("loopback invoked outside NT");
    cust_follow_a: assert property (@(posedge clock) disable iff (!rst_b)
        m4_mode == MCRL_M4_DUAL_VER && verified_act |=> customer_transparent)
        else $error("transparency does not follow verified act");

endmodule

// ==== tb/mcrl_far_end.sv ====
`timescale 1ns/1ps

// Far-end transceiver as seen through the deframer: sends eoc and M4 frames
module mcrl_far_end
    import mcrl_pkg::*;
(
    // Clock
    input wire logic clock,
    // Received maintenance data
    output mcrl_eoc_type eoc_rx,
    output logic eoc_frame,
    output logic [7:0] m4_rx,
    output logic m4_frame
);
    // Idle lines
    initial
    begin
        eoc_frame = 1'b0;
        m4_frame = 1'b0;
        eoc_rx = '0;
        m4_rx = 8'h00;
    end

    // One eoc frame; data inverts afterwards so a stale word is never mistaken for a new one
    task automatic send_eoc(input mcrl_eoc_type w);
        @(posedge clock);
        eoc_frame <= 1'b1;
        eoc_rx <= w;
        @(posedge clock);
        eoc_frame <= 1'b0;
        eoc_rx <= ~w;
    endtask

    // One superframe worth of M4 bits
    task automatic send_m4(input logic [7:0] b);
        @(posedge clock);
        m4_frame <= 1'b1;
        m4_rx <= b;
        @(posedge clock);
        m4_frame <= 1'b0;
        m4_rx <= ~b;
    endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps

module tb_top
    import mcrl_pkg::*;
;
    logic clock, rst_b, read, write, waitrequest, nt_mode, linkup, sf_sync, sf_detect;
    logic eoc_frame, m4_frame, crc_invert, customer_transparent, deact_response;
    logic eoc_load_interrupt, m4_change_interrupt;
    logic [5:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, r;
    logic [7:0] m4_rx;
    mcrl_eoc_type eoc_rx, eoc_tx;
    mcrl_func_type loop_ctrl;
    logic [5:0] ofs [4] = '{6'h00, 6'h04, 6'h10, 6'h20};
    int errors, checks;

    // 100 ns clock
    always #50 clock = ~clock;

    mcrl_top u_mcrl_top (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .nt_mode(nt_mode), .linkup(linkup), .sf_sync(sf_sync),
        .sf_detect(sf_detect), .eoc_frame(eoc_frame), .eoc_rx(eoc_rx), .m4_frame(m4_frame),
        .m4_rx(m4_rx), .eoc_tx(eoc_tx), .loop_ctrl(loop_ctrl), .crc_invert(crc_invert),
        .customer_transparent(customer_transparent), .deact_response(deact_response),
        .eoc_load_interrupt(eoc_load_interrupt), .m4_change_interrupt(m4_change_interrupt));

    mcrl_far_end u_mcrl_far_end (.clock(clock), .eoc_rx(eoc_rx), .eoc_frame(eoc_frame),
        .m4_rx(m4_rx), .m4_frame(m4_frame));

    // Avalon access; sampled values after the edge are those standing at it
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do @(posedge clock); while (waitrequest !== 1'b0);
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic eoc(input mcrl_eoc_type w, input int n);
        repeat (n) u_mcrl_far_end.send_eoc(w);
        repeat (3) @(posedge clock);
    endtask

    task automatic complete_run;
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog, well beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        complete_run;
    end

    initial
    begin
        clock = 0; rst_b = 0; read = 0; write = 0; address = 0; writedata = 0;
        byteenable = 4'hf; nt_mode = 1; linkup = 1; sf_sync = 1; sf_detect = 1;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        // Reset values and an unmapped address
        for (int i = 0; i < 4; i++)
        begin
            bus(0, ofs[i], 0);
            chk(r, 32'h0);
        end
        // NT trinal-check with echo, host word, Hold substitution
        bus(1, 6'h00, 32'h80);
        bus(1, 6'h0c, 32'h1a5);
        eoc(12'h151, 1);
        chk(eoc_tx, 12'h151);
        eoc(12'h151, 1);
        bus(0, 6'h08, 0);
        chk(r, 32'h0);
        eoc(12'h151, 1);
        bus(0, 6'h08, 0);
        chk(r, 32'h151);
        bus(0, 6'h18, 0);
        chk(r, 32'h4);
        chk(eoc_load_interrupt, 1'b1);
        chk(eoc_tx, 12'h1a5);
        bus(1, 6'h18, 32'h4);
        eoc(12'h651, 1);
        chk(eoc_tx, 12'h100);
        // Loss of linkup between frames restarts the count
        eoc(12'h152, 2);
        linkup <= 1'b0;
        @(posedge clock);
        linkup <= 1'b1;
        eoc(12'h152, 1);
        bus(0, 6'h08, 0);
        chk(r, 32'h151);
        // Every-frame mode, blocked while superframe detect is low
        bus(1, 6'h00, 32'hc0);
        sf_detect <= 1'b0;
        eoc(12'h155, 1);
        bus(0, 6'h08, 0);
        chk(r, 32'h151);
        sf_detect <= 1'b1;
        eoc(12'h155, 1);
        bus(0, 6'h08, 0);
        chk(r, 32'h155);
        // LT trinal restarts on a host transmit write; LT mode 0,0 is plain trinal
        nt_mode <= 1'b0;
        bus(1, 6'h00, 32'h00);
        eoc(12'h156, 2);
        bus(1, 6'h0c, 32'h1a6);
        eoc(12'h156, 1);
        bus(0, 6'h08, 0);
        chk(r, 32'h155);
        eoc(12'h156, 2);
        bus(0, 6'h08, 0);
        chk(r, 32'h156);
        chk(loop_ctrl, 5'h0);
        // Automatic processor in NT
        nt_mode <= 1'b1;
        bus(1, 6'h00, 32'h40);
        eoc(12'h151, 3);
        chk(loop_ctrl.loop_b1, 1'b1);
        eoc(12'h153, 3);
        chk(crc_invert, 1'b1);
        eoc(12'h154, 3);
        chk({loop_ctrl.loop_b1, crc_invert}, 2'h3);
        eoc(12'h1ff, 3);
        chk({loop_ctrl, crc_invert}, 6'h0);
        eoc(12'h177, 3);
        chk(eoc_tx, 12'h1aa);
        bus(0, 6'h08, 0);
        chk(r, 32'h177);
        eoc(12'h351, 3);
        chk(eoc_tx, 12'h100);
        // M4 dual consecutive with verified act
        bus(1, 6'h18, 32'h6);
        u_mcrl_far_end.send_m4(8'h00);
        u_mcrl_far_end.send_m4(8'h81);
        bus(0, 6'h10, 0);
        chk(r, 32'h0);
        u_mcrl_far_end.send_m4(8'h11);
        bus(0, 6'h10, 0);
        chk(r, 32'h1);
        bus(0, 6'h18, 0);
        chk(r, 32'h2);
        chk(customer_transparent, 1'b1);
        // Preset while unsynced, reloaded when sync returns
        bus(1, 6'h18, 32'h2);
        sf_sync <= 1'b0;
        u_mcrl_far_end.send_m4(8'hff);
        bus(1, 6'h10, 32'h3c);
        bus(0, 6'h18, 0);
        chk(r, 32'h0);
        sf_sync <= 1'b1;
        repeat (3) @(posedge clock);
        bus(0, 6'h10, 0);
        chk(r, 32'h3c);
        chk(customer_transparent, 1'b0);
        // Every mode
        bus(1, 6'h00, 32'h30);
        u_mcrl_far_end.send_m4(8'h5a);
        bus(0, 6'h10, 0);
        chk(r, 32'h5a);
        bus(0, 6'h18, 0);
        chk(r, 32'h2);
        chk(m4_change_interrupt, 1'b1);
        // Delta mode loads only on a difference
        bus(1, 6'h18, 32'h2);
        bus(1, 6'h00, 32'h20);
        u_mcrl_far_end.send_m4(8'h5a);
        bus(0, 6'h18, 0);
        chk(r, 32'h0);
        u_mcrl_far_end.send_m4(8'h3c);
        bus(0, 6'h10, 0);
        chk(r, 32'h3c);
        // Trinal option on act, dea and uoa; dual on the rest
        bus(1, 6'h00, 32'h00);
        bus(1, 6'h04, 32'h20);
        u_mcrl_far_end.send_m4(8'h03);
        u_mcrl_far_end.send_m4(8'h03);
        bus(0, 6'h10, 0);
        chk(r, 32'h0);
        u_mcrl_far_end.send_m4(8'h03);
        bus(0, 6'h10, 0);
        chk(r, 32'h3);
        chk(customer_transparent, 1'b1);
        // Verified dea in NT, dual checked
        bus(1, 6'h04, 32'h00);
        repeat (2) u_mcrl_far_end.send_m4(8'h01);
        bus(0, 6'h14, 0);
        chk(r, 32'h3f);
        chk(deact_response, 1'b1);
        // Dual-only mode keeps verified bits out of transparency
        bus(1, 6'h00, 32'h10);
        repeat (2) u_mcrl_far_end.send_m4(8'h00);
        bus(0, 6'h10, 0);
        chk(r, 32'h0);
        chk(customer_transparent, 1'b0);
        complete_run;
    end
endmodule
